// File: cesf_cfg.svh
// Offsets, field positions, reset values and sizes of the crypto status block
`ifndef CESF_CFG_SVH
`define CESF_CFG_SVH

// ==========================================================================
// Register byte offsets
`define CESF_OFF_STATUS      12'h000
`define CESF_OFF_CONTROL     12'h004
`define CESF_OFF_IRQ_STATUS  12'h008
`define CESF_OFF_IRQ_MASK    12'h00c

// ==========================================================================
// Status register fields
`define CESF_ST_BUSY         7
`define CESF_ST_TXTA_BUSY    6
`define CESF_ST_ABORTED      5
`define CESF_ST_WRAP         4
`define CESF_ST_MODE_FAIL    2
`define CESF_ST_KEY_FAIL     1
`define CESF_ST_PGM_FAIL     0
`define CESF_ST_WIDTH        16

// ==========================================================================
// Control register fields
`define CESF_CT_ENABLE       0
`define CESF_CT_DISABLE      1
`define CESF_CT_GO           2
`define CESF_CT_PGM_WRITE    3
`define CESF_CT_PAGE_LSB     4
`define CESF_CT_PAGE_WIDTH   4
`define CESF_CT_RESET        8'h00

// ==========================================================================
// Interrupt fields, shared by status and mask
`define CESF_IRQ_DONE        0
`define CESF_IRQ_ABORT       1
`define CESF_IRQ_WRAP        2
`define CESF_IRQ_CFG_FAIL    3
`define CESF_IRQ_WIDTH       4
`define CESF_IRQ_RESET       4'h0

// ==========================================================================
// Sizes
`define CESF_NUM_PAGES       16

`endif

// File: cesf_pkg.sv
// Types shared by the crypto status block
package cesf_pkg;

  // ========================================================================
  // Operation state, mirrored as the go bit
  typedef enum logic [0:0] {
    CESF_OP_IDLE = 1'b0,
    CESF_OP_RUN  = 1'b1
  } cesf_op_state_t;

  // ========================================================================
  // Events and levels coming from the cipher datapath and key store
  typedef struct packed {
    logic op_done;      // Operation ran to its end
    logic ctr_wrap;     // Counter in text buffer B wrapped
    logic otp_busy;     // Key store program or erase in progress
    logic otp_read;     // Key store read in progress, incl. power-on read
    logic text_a_full;  // Text buffer A cannot accept data
    logic pgm_done;     // Key programming finished
  } cesf_engine_in_t;

  // ========================================================================
  // Configuration checks from the mode and key registers
  typedef struct packed {
    logic mode_illegal; // Operating and cipher mode pair is illegal
    logic key_illegal;  // Key and mode settings are illegal
  } cesf_cfg_in_t;

endpackage

// File: cesf_cfg_check.sv
// Configuration fail flags of the crypto status block
`include "cesf_cfg.svh"

module cesf_cfg_check #(
  parameter int NUM_PAGES = `CESF_NUM_PAGES,
  parameter int PAGE_W    = `CESF_CT_PAGE_WIDTH
) (
  input  wire logic                 clk,           // System clock
  input  wire logic                 rstn,          // Synchronous reset, active low
  input  wire logic                 disable_ctl,   // Module disable control
  input  wire logic                 otp_read,      // Key store read in progress
  input  cesf_pkg::cesf_cfg_in_t    cfg,           // Configuration legality
  input  wire logic [PAGE_W-1:0]    page_sel,      // Selected key page
  input  wire logic [NUM_PAGES-1:0] page_unavail,  // Reserved or locked pages
  output logic                      mode_fail,     // Mode invalid flag
  output logic                      key_fail,      // Key invalid flag
  output logic                      pgm_fail       // Program fail flag
);

  initial begin
    if (NUM_PAGES != (1 << PAGE_W)) begin
      $error("cesf_cfg_check: NUM_PAGES must equal 2**PAGE_W");
    end
  end

  // ========================================================================
  // Evaluation, independent of the module enable
  logic page_bad;
  logic next_mode_fail;
  logic next_key_fail;
  logic next_pgm_fail;

  assign page_bad       = page_unavail[page_sel];
  assign next_mode_fail = cfg.mode_illegal;
  assign next_key_fail  = otp_read | cfg.key_illegal;
  assign next_pgm_fail  = otp_read | page_bad;

  // ========================================================================
  // Flags
  always_ff @(posedge clk) begin
    if (!rstn || disable_ctl) begin
      mode_fail <= 1'b0;
      key_fail  <= 1'b0;
      pgm_fail  <= 1'b0;
    end else begin
      mode_fail <= next_mode_fail;
      key_fail  <= next_key_fail;
      pgm_fail  <= next_pgm_fail;
    end
  end

endmodule // cesf_cfg_check

// File: cesf_status.sv
// Crypto engine status flags with APB register access
//
// Overview of operation
// - Busy high during crypto or key-store work
// - Buffer A busy flag; software then waits
// - Software go clear sets aborted flag
// - Completion clears go, aborted stays zero
// - Counter wrap sets rollover flag
// - Rollover set blocks go until cleared
// - Illegal mode flags and blocks program write
// - Illegal key flags and blocks program write
// - Reset or disable clears busy, fail flags
// - Aborted, rollover cleared by disable, zero write
// - Fail flags evaluated while module not enabled
// - Key reads force busy, key, program fail
// - Aborted flag blocks go, not program write
// - Upper byte and bit 3 read zero
//
// Local design decisions: the address map and the APB register port.
`include "cesf_cfg.svh"

module cesf_status #(
  parameter int NUM_PAGES = `CESF_NUM_PAGES,
  parameter int PAGE_W    = `CESF_CT_PAGE_WIDTH
) (
  input  wire logic                 clk,           // System clock, 200 MHz
  input  wire logic                 rstn,          // Synchronous reset, active low
  input  wire logic                 psel,          // APB select
  input  wire logic                 penable,       // APB access phase
  input  wire logic                 pwrite,        // APB write
  input  wire logic [11:0]          paddr,         // APB byte address
  input  wire logic [31:0]          pwdata,        // APB write data
  output logic [31:0]               prdata,        // APB read data
  output logic                      pready,        // APB ready
  output logic                      pslverr,       // APB error, unmapped address
  input  cesf_pkg::cesf_engine_in_t eng,           // Datapath events and levels
  input  cesf_pkg::cesf_cfg_in_t    cfg,           // Configuration legality
  input  wire logic [NUM_PAGES-1:0] page_unavail,  // Reserved or locked pages
  output logic                      module_enable, // Engine enabled
  output logic                      operation_go,  // Operation running
  output logic                      op_start,      // Pulse, operation begins
  output logic                      program_write_start, // Key programming running
  output logic [PAGE_W-1:0]         key_page_select, // Selected key page
  output logic                      irq            // Level interrupt
);

  initial begin
    if (PAGE_W != `CESF_CT_PAGE_WIDTH || NUM_PAGES != (1 << PAGE_W)) begin
      $error("cesf_status: page field must be 4 bits over 16 pages");
    end
  end

  // ========================================================================
  // APB decode
  logic setup_ph;
  logic access_ph;
  logic hit_status;
  logic hit_control;
  logic hit_irq_st;
  logic hit_irq_mask;
  logic hit_any;
  logic wr_status;
  logic wr_control;
  logic wr_irq_st;
  logic wr_irq_mask;

  assign setup_ph     = psel & ~penable;
  assign access_ph    = psel & penable;
  assign hit_status   = (paddr == `CESF_OFF_STATUS);
  assign hit_control  = (paddr == `CESF_OFF_CONTROL);
  assign hit_irq_st   = (paddr == `CESF_OFF_IRQ_STATUS);
  assign hit_irq_mask = (paddr == `CESF_OFF_IRQ_MASK);
  assign hit_any      = hit_status | hit_control | hit_irq_st | hit_irq_mask;
  assign wr_status    = access_ph & pwrite & hit_status;
  assign wr_control   = access_ph & pwrite & hit_control;
  assign wr_irq_st    = access_ph & pwrite & hit_irq_st;
  assign wr_irq_mask  = access_ph & pwrite & hit_irq_mask;

  // No wait states; read data is captured in the setup cycle
  assign pready = access_ph;

  // ========================================================================
  // Control register
  logic                   enable_bit;
  logic                   disable_bit;
  logic                   pgm_write;
  logic [PAGE_W-1:0]      page_sel;
  cesf_pkg::cesf_op_state_t op_state;
  logic                   aborted;
  logic                   wrapped;
  logic                   engine_busy;
  logic                   txta_busy;
  logic                   mode_fail;
  logic                   key_fail;
  logic                   pgm_fail;

  logic                   go_req;
  logic                   pgm_req;
  logic                   running;
  logic                   any_fail;
  logic                   hw_done;
  logic                   sw_abort;
  logic                   go_grant;
  logic                   pgm_grant;
  cesf_pkg::cesf_op_state_t next_op_state;
  logic                   next_pgm_write;

  assign go_req   = pwdata[`CESF_CT_GO];
  assign pgm_req  = pwdata[`CESF_CT_PGM_WRITE];
  assign running  = (op_state == cesf_pkg::CESF_OP_RUN);
  assign any_fail = mode_fail | key_fail | pgm_fail;
  assign hw_done  = running & eng.op_done;
  assign sw_abort = wr_control & running & ~go_req & ~hw_done & ~disable_bit;
  assign go_grant = wr_control & go_req & ~running & enable_bit & ~disable_bit
                    & ~aborted & ~wrapped;
  assign pgm_grant = wr_control & pgm_req & ~pgm_write & enable_bit & ~disable_bit
                     & ~any_fail;

  always_comb begin
    next_op_state = op_state;
    case (op_state)
      cesf_pkg::CESF_OP_IDLE: begin
        if (go_grant) begin
          next_op_state = cesf_pkg::CESF_OP_RUN;
        end
      end
      cesf_pkg::CESF_OP_RUN: begin
        if (disable_bit || !enable_bit || hw_done || sw_abort) begin
          next_op_state = cesf_pkg::CESF_OP_IDLE;
        end
      end
      default: begin
        next_op_state = cesf_pkg::CESF_OP_IDLE;
      end
    endcase
  end

  // No programming on a bad page already selected by an earlier control write
  assign next_pgm_write = disable_bit ? 1'b0 :
                          pgm_grant ? 1'b1 :
                          (eng.pgm_done ? 1'b0 : pgm_write);

  always_ff @(posedge clk) begin
    if (!rstn) begin
      enable_bit  <= 1'b0;
      disable_bit <= 1'b0;
      page_sel    <= '0;
      op_state    <= cesf_pkg::CESF_OP_IDLE;
      pgm_write   <= 1'b0;
    end else begin
      if (wr_control) begin
        enable_bit  <= pwdata[`CESF_CT_ENABLE];
        disable_bit <= pwdata[`CESF_CT_DISABLE];
        page_sel    <= pwdata[`CESF_CT_PAGE_LSB +: PAGE_W];
      end
      op_state  <= next_op_state;
      pgm_write <= next_pgm_write;
    end
  end

  // Start pulse only on a granted idle-to-run step
  assign op_start            = go_grant;
  assign operation_go        = running;
  assign program_write_start = pgm_write;
  assign module_enable       = enable_bit;
  assign key_page_select     = page_sel;

  // ========================================================================
  // Aborted and rollover flags
  logic clr_aborted;
  logic clr_wrapped;
  logic set_wrapped;

  // Writing zero clears; ones are ignored
  assign clr_aborted = wr_status & ~pwdata[`CESF_ST_ABORTED];
  assign clr_wrapped = wr_status & ~pwdata[`CESF_ST_WRAP];
  assign set_wrapped = running & eng.ctr_wrap & ~disable_bit;

  always_ff @(posedge clk) begin
    if (!rstn || disable_bit) begin
      aborted <= 1'b0;
      wrapped <= 1'b0;
    end else begin
      aborted <= sw_abort | (aborted & ~clr_aborted & ~hw_done);
      wrapped <= set_wrapped | (wrapped & ~clr_wrapped);
    end
  end

  // ========================================================================
  // Busy flags
  always_ff @(posedge clk) begin
    if (!rstn || disable_bit) begin
      engine_busy <= 1'b0;
      txta_busy   <= 1'b0;
    end else begin
      engine_busy <= next_op_state == cesf_pkg::CESF_OP_RUN
                     | next_pgm_write | eng.otp_busy | eng.otp_read;
      txta_busy   <= eng.text_a_full;
    end
  end

  // ========================================================================
  // Configuration fail flags
  cesf_cfg_check #(
    .NUM_PAGES (NUM_PAGES),
    .PAGE_W    (PAGE_W)
  ) u_cfg_check (
    .clk          (clk),
    .rstn         (rstn),
    .disable_ctl  (disable_bit),
    .otp_read     (eng.otp_read),
    .cfg          (cfg),
    .page_sel     (page_sel),
    .page_unavail (page_unavail),
    .mode_fail    (mode_fail),
    .key_fail     (key_fail),
    .pgm_fail     (pgm_fail)
  );

  // ========================================================================
  // Status word
  logic [`CESF_ST_WIDTH-1:0] status_word;

  always_comb begin
    status_word                       = '0;
    status_word[`CESF_ST_BUSY]        = engine_busy;
    status_word[`CESF_ST_TXTA_BUSY]   = txta_busy;
    status_word[`CESF_ST_ABORTED]     = aborted;
    status_word[`CESF_ST_WRAP]        = wrapped;
    status_word[`CESF_ST_MODE_FAIL]   = mode_fail;
    status_word[`CESF_ST_KEY_FAIL]    = key_fail;
    status_word[`CESF_ST_PGM_FAIL]    = pgm_fail;
  end

  // ========================================================================
  // Interrupts
  logic [`CESF_IRQ_WIDTH-1:0] irq_status;
  logic [`CESF_IRQ_WIDTH-1:0] irq_mask;
  logic [`CESF_IRQ_WIDTH-1:0] irq_event;
  logic [`CESF_IRQ_WIDTH-1:0] irq_clear;
  logic                       fail_now;
  logic                       fail_prev;

  assign fail_now  = mode_fail | key_fail | pgm_fail;
  assign irq_clear = wr_irq_st ? pwdata[`CESF_IRQ_WIDTH-1:0] : '0;

  always_comb begin
    irq_event                     = '0;
    irq_event[`CESF_IRQ_DONE]     = hw_done;
    irq_event[`CESF_IRQ_ABORT]    = sw_abort;
    irq_event[`CESF_IRQ_WRAP]     = set_wrapped;
    // Rising edge only, so a held fail does not re-fire after clear
    irq_event[`CESF_IRQ_CFG_FAIL] = fail_now & ~fail_prev;
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      irq_status <= `CESF_IRQ_RESET;
      irq_mask   <= `CESF_IRQ_RESET;
      fail_prev  <= 1'b0;
    end else begin
      // Set wins over write-one clear
      irq_status <= irq_event | (irq_status & ~irq_clear);
      if (wr_irq_mask) begin
        irq_mask <= pwdata[`CESF_IRQ_WIDTH-1:0];
      end
      fail_prev <= fail_now;
    end
  end

  assign irq = |(irq_status & irq_mask);

  // ========================================================================
  // Read data, captured in the setup cycle
  logic [31:0] ctrl_word;
  logic [31:0] rd_mux;

  always_comb begin
    ctrl_word                                = 32'h0000_0000;
    ctrl_word[`CESF_CT_ENABLE]               = enable_bit;
    ctrl_word[`CESF_CT_DISABLE]              = disable_bit;
    ctrl_word[`CESF_CT_GO]                   = running;
    ctrl_word[`CESF_CT_PGM_WRITE]            = pgm_write;
    ctrl_word[`CESF_CT_PAGE_LSB +: PAGE_W]   = page_sel;
  end

  assign rd_mux = hit_status   ? {16'h0000, status_word} :
                  hit_control  ? ctrl_word :
                  hit_irq_st   ? {28'h0000000, irq_status} :
                  hit_irq_mask ? {28'h0000000, irq_mask} :
                  32'h0000_0000;

  always_ff @(posedge clk) begin
    if (!rstn) begin
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else if (setup_ph) begin
      prdata  <= pwrite ? 32'h0000_0000 : rd_mux;
      pslverr <= ~hit_any;
    end
  end

endmodule // cesf_status

// File: cesf_status_props.sv
// Concurrent checks on the ports of the crypto status block
module cesf_status_props #(
  parameter int NUM_PAGES = 16,
  parameter int PAGE_W    = 4
) (
  input wire logic                 clk,                 // System clock
  input wire logic                 rstn,                // Reset, active low
  input wire logic                 psel,                // APB select
  input wire logic                 penable,             // APB access phase
  input wire logic                 pwrite,              // APB write
  input wire logic [11:0]          paddr,               // APB address
  input wire logic [31:0]          pwdata,              // APB write data
  input wire logic [31:0]          prdata,              // APB read data
  input wire logic                 pready,              // APB ready
  input wire logic                 pslverr,             // APB error
  input cesf_pkg::cesf_engine_in_t eng,                 // Datapath events
  input cesf_pkg::cesf_cfg_in_t    cfg,                 // Configuration legality
  input wire logic [NUM_PAGES-1:0] page_unavail,        // Locked pages
  input wire logic                 module_enable,       // Engine enabled
  input wire logic                 operation_go,        // Operation running
  input wire logic                 op_start,            // Start pulse
  input wire logic                 program_write_start, // Programming running
  input wire logic [PAGE_W-1:0]    key_page_select,     // Selected page
  input wire logic                 irq                  // Interrupt
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  // ==========================================================================
  // Bus
  chk_ready_zero_wait: assert property (pready == (psel && penable))
    else $error("pready differs from access phase");
  chk_unmapped_err: assert property (
    psel && penable && paddr > 12'h00c |-> pslverr && prdata == 32'h0)
    else $error("unmapped access not refused");
  chk_rsvd_read_zero: assert property (
    psel && penable && !pwrite && paddr == 12'h000 |-> prdata[31:8] == 24'h0 && !prdata[3])
    else $error("reserved status bits read nonzero");

  // ==========================================================================
  // Operation
  // Busy while running
  chk_busy_while_go: assert property (
    psel && !penable && !pwrite && paddr == 12'h000 && operation_go && $past(operation_go)
    |=> prdata[7]) else $error("busy not set while running");
  chk_done_ends_go: assert property (operation_go && eng.op_done |=> !operation_go)
    else $error("go not cleared on completion");
  chk_go_from_start: assert property ($rose(operation_go) |-> $past(op_start))
    else $error("go rose without a start");
  chk_start_legal: assert property (
    op_start |-> module_enable && !operation_go && psel && penable && pwrite
    && paddr == 12'h004)
    else $error("start outside an enabled control write");

  // ==========================================================================
  // Program write blocking; flag seen at the write came from inputs one edge earlier
  // Mode fail blocks
  chk_mode_blocks: assert property (
    $rose(program_write_start) |-> !$past(cfg.mode_illegal, 2))
    else $error("program write accepted with illegal mode");
  chk_key_blocks: assert property (
    $rose(program_write_start) |-> !$past(cfg.key_illegal, 2))
    else $error("program write accepted with illegal key");
  chk_page_blocks: assert property (
    $rose(program_write_start) |-> !$past(page_unavail[key_page_select], 2))
    else $error("program write accepted on locked page");
  chk_reset_quiet: assert property (disable iff (1'b0)
    !rstn |=> !operation_go && !program_write_start && !irq && !module_enable)
    else $error("outputs not cleared by reset");
endmodule // cesf_status_props

// File: testbench.sv
// Self-checking bench of the crypto status block
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic                      clk, rstn, psel, penable, pwrite, pready, pslverr, er;
  logic                      module_enable, operation_go, op_start, program_write_start, irq;
  logic [11:0]               paddr;
  logic [31:0]               pwdata, prdata, rd, seed;
  logic [15:0]               page_unavail;
  logic [3:0]                key_page_select, pg;
  cesf_pkg::cesf_engine_in_t eng;
  cesf_pkg::cesf_cfg_in_t    cfg;
  int                        err_total, check_count;

  cesf_status dut_u (.clk(clk), .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .eng(eng), .cfg(cfg), .page_unavail(page_unavail), .module_enable(module_enable),
    .operation_go(operation_go), .op_start(op_start), .program_write_start(program_write_start),
    .key_page_select(key_page_select), .irq(irq));

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // ==========================================================================
  // Helpers
  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // Flags busy,textA,abort,wrap,mode,key,pgm; bit 3 stays zero
  function automatic logic [31:0] st_exp(input logic [6:0] f);
    return {24'h0, f[6:3], 1'b0, f[2:0]};
  endfunction
  task check(input string nm, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      err_total++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1 && n++ < 20);
    if (pready !== 1'b1) begin
      err_total++;
      $display("Error pready expected 1 seen %b", pready);
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask
  task wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task rdchk(input string nm, input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    check(nm, e, rd);
  endtask
  // Output 0 go, 1 program write, 2 irq; looked at mid-cycle
  task out_chk(input int k, input logic e);
    logic g;
    @(negedge clk);
    g = (k == 0) ? operation_go : (k == 1) ? program_write_start : irq;
    check(k == 0 ? "operation_go" : k == 1 ? "program_write_start" : "irq", {31'h0, e}, {31'h0, g});
    @(posedge clk);
  endtask
  // Event 0 done, 1 wrap, 2 programming done
  task pulse(input int k);
    case (k)
      0: eng.op_done <= 1'b1;
      1: eng.ctr_wrap <= 1'b1;
      default: eng.pgm_done <= 1'b1;
    endcase
    @(posedge clk);
    eng.op_done <= 1'b0; eng.ctr_wrap <= 1'b0; eng.pgm_done <= 1'b0;
    @(posedge clk);
  endtask
  task print_verdict;
    if (err_total == 0 && check_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge clk);
    err_total++;
    print_verdict;
  end

  // ==========================================================================
  // Main sequence
  initial begin
    rstn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 12'h0; pwdata = 32'h0;
    eng = '0; cfg = '0; page_unavail = 16'h0; seed = 32'h9b16; err_total = 0; check_count = 0;
    repeat (8) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    rdchk("status", 12'h000, st_exp(7'h00));
    rdchk("control", 12'h004, 32'h0);
    seed = lfsr_next(seed);
    wr(12'h000, seed | 32'h30); rdchk("status", 12'h000, st_exp(7'h00));
    apb(1'b0, 12'h010, 32'h0); check("pslverr", 32'h1, {31'h0, er});
    // Normal run with done interrupt; go is only taken once enable already stands
    wr(12'h00c, 32'h1); wr(12'h004, 32'h1);
    wr(12'h004, 32'h5); out_chk(0, 1'b1); out_chk(2, 1'b0);
    rdchk("status", 12'h000, st_exp(7'h40));
    pulse(0); out_chk(0, 1'b0);
    rdchk("status", 12'h000, st_exp(7'h00));
    out_chk(2, 1'b1); rdchk("irq_status", 12'h008, 32'h1);
    wr(12'h00c, 32'h0); out_chk(2, 1'b0); wr(12'h008, 32'h1); wr(12'h00c, 32'h1); out_chk(2, 1'b0);
    // Abort by software, then blocked until cleared
    wr(12'h004, 32'h5); wr(12'h004, 32'h1); out_chk(0, 1'b0);
    rdchk("status", 12'h000, st_exp(7'h10));
    wr(12'h004, 32'h5); out_chk(0, 1'b0);
    wr(12'h000, seed | 32'h20); rdchk("status", 12'h000, st_exp(7'h10));
    wr(12'h000, 32'h0); rdchk("status", 12'h000, st_exp(7'h00));
    // Counter wrap sticks and blocks the next start
    wr(12'h004, 32'h5); pulse(1); rdchk("status", 12'h000, st_exp(7'h48));
    pulse(0); wr(12'h004, 32'h5); out_chk(0, 1'b0);
    wr(12'h000, 32'h0); wr(12'h004, 32'h5); out_chk(0, 1'b1); pulse(0);
    // Disable wipes sticky and fail flags
    wr(12'h004, 32'h5); wr(12'h004, 32'h1); cfg.mode_illegal <= 1'b1;
    wr(12'h004, 32'h3); rdchk("status", 12'h000, st_exp(7'h00));
    cfg <= '0; wr(12'h004, 32'h0);
    // Done, abort, wrap and config fail all seen since the last clear
    rdchk("irq_status", 12'h008, 32'hf); wr(12'h008, 32'hf);
    // Fail flags, evaluated while not enabled, each blocking programming once enabled
    seed = lfsr_next(seed); pg = seed[3:0]; page_unavail <= seed[31:16] & ~(16'h1 << pg);
    for (int i = 0; i < 3; i++) begin
      wr(12'h004, {24'h0, pg, 4'h0});
      case (i)
        0: cfg.mode_illegal <= 1'b1;
        1: cfg.key_illegal <= 1'b1;
        default: page_unavail[pg] <= 1'b1;
      endcase
      @(posedge clk);
      rdchk("status", 12'h000, st_exp(7'h1 << (2 - i)));
      wr(12'h004, {24'h0, pg, 4'h1});
      wr(12'h004, {24'h0, pg, 4'h9}); out_chk(1, 1'b0);
      cfg <= '0; page_unavail[pg] <= 1'b0;
    end
    rdchk("irq_status", 12'h008, 32'h8);
    wr(12'h004, {24'h0, pg, 4'h9}); out_chk(1, 1'b1);
    rdchk("control", 12'h004, {24'h0, pg, 4'h9});
    check("key_page_select", {28'h0, pg}, {28'h0, key_page_select});
    check("module_enable", 32'h1, {31'h0, module_enable});
    rdchk("status", 12'h000, st_exp(7'h40));
    pulse(2); out_chk(1, 1'b0);
    // Key store read forces flags
    eng.otp_read <= 1'b1; @(posedge clk); rdchk("status", 12'h000, st_exp(7'h43));
    eng.otp_read <= 1'b0; @(posedge clk); rdchk("status", 12'h000, st_exp(7'h00));
    eng.text_a_full <= 1'b1; @(posedge clk); rdchk("status", 12'h000, st_exp(7'h20));
    // System reset in mid-run clears go, control and sticky flags
    eng <= '0; page_unavail <= 16'h0; wr(12'h004, 32'h5); pulse(1);
    rstn <= 1'b0; repeat (2) @(posedge clk); rstn <= 1'b1; @(posedge clk);
    out_chk(0, 1'b0); rdchk("status", 12'h000, st_exp(7'h00));
    rdchk("control", 12'h004, 32'h0);
    print_verdict;
  end
endmodule // testbench

bind cesf_status cesf_status_props #(.NUM_PAGES(NUM_PAGES), .PAGE_W(PAGE_W)) chk_u (
  .clk(clk), .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .eng(eng), .cfg(cfg),
  .page_unavail(page_unavail), .module_enable(module_enable), .operation_go(operation_go),
  .op_start(op_start), .program_write_start(program_write_start),
  .key_page_select(key_page_select), .irq(irq));
